/* hdl/sbul_core.sv */
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sbul_core
	import sbul_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Instruction issue
	input  wire logic        iss_valid,
	input  wire logic [31:0] iss_insn,
	input  wire logic [63:0] iss_base,
	output logic             uld_busy,
	// Store stream
	input  wire store_s      st,
	input  wire logic        st_done_valid,
	input  wire logic        st_done_marked,
	input  wire logic        io_posted,
	output logic             stall_unmarked,
	output logic             stall_marked,
	output logic             wb_flush,
	// Memory reads
	output logic             rd_req,
	output logic      [63:0] rd_addr,
	input  wire rd_resp_s    rd_resp,
	// Results
	output logic             ld_done,
	output logic      [4:0]  ld_rt,
	output logic      [63:0] ld_data,
	output logic             exc_valid,
	output exc_e             exc_code,
	output logic             insn_nop,
	output logic             partial_go
);

	// ==========================================
	// State
	typedef enum logic [1:0] {U_IDLE, U_WAIT0, U_WAIT1} uld_e;

	typedef struct packed {
		uld_e        fsm;
		logic [3:0]  ctrl;
		logic [7:0]  memctl;
		logic [31:0] rdata;
		logic        bar_all;
		logic        bar_um;
		cnt_t        cnt_um;
		cnt_t        cnt_mk;
		logic [63:0] va;
		logic [4:0]  rt;
		logic [63:0] d0;
		logic        rd_req;
		logic [63:0] rd_addr;
		logic        done;
		logic [63:0] data;
		logic        exc;
		exc_e        code;
		logic        nop;
		logic        partial;
		logic        busy;
		logic        flush;
		logic        stall_um;
		logic        stall_mk;
	} state_s;

	state_s s_q;
	state_s s_d;

	// ==========================================
	// Helpers

	// Scratch segment fault for one virtual address
	function automatic logic seg_fault(input logic [63:0] a, input logic [7:0] mc);
		logic sio;
		logic lm;
		logic over;
		sio  = a[63:SIO_TOP] == SIO_BASE[63:SIO_TOP];
		lm   = a[63:LM_TOP] == LM_BASE[63:LM_TOP];
		over = a[LM_TOP-1:LM_LINE] > mc[MC_LMSZ +: 6];
		return mc[MC_SEGENA] && (sio || (lm && over));
	endfunction

	// Aligned doubleword address
	function automatic logic [63:0] dw_align(input logic [63:0] a);
		return {a[63:3], 3'h0};
	endfunction

	// ==========================================
	// Submodules
	insn_dec_s   dec;
	logic [63:0] merged;
	logic [63:0] eff_va;
	logic [63:0] next_va;

	insn_decode u_dec (
		.insn      (iss_insn),
		.unal_en   (s_q.ctrl[CTL_UNAL]),
		.left_only (s_q.ctrl[CTL_LONLY]),
		.little    (s_q.ctrl[CTL_LE]),
		.dec       (dec)
	);

	dword_merge u_merge (
		.d0  (s_q.d0),
		.d1  (rd_resp.data),
		.lo  (s_q.va[2:0]),
		.big (~s_q.ctrl[CTL_LE]),
		.q   (merged)
	);

	// Effective address and its successor
	assign eff_va  = iss_base + {{48{iss_insn[15]}}, iss_insn[15:0]};
	assign next_va = s_q.va + DW_BYTES;

	// ==========================================
	// Next state
	logic inc_um;
	logic inc_mk;
	logic [1:0] dec_um;
	logic dec_mk;
	logic go;

	always_comb begin
		s_d = s_q;
		s_d.rd_req  = 1'b0;
		s_d.done    = 1'b0;
		s_d.exc     = 1'b0;
		s_d.nop     = 1'b0;
		s_d.partial = 1'b0;
		s_d.rdata   = 32'h0000_0000;
		go = iss_valid && (s_q.fsm == U_IDLE);
		// Register writes
		if (reg_wr && reg_addr == REG_CTRL) begin
			s_d.ctrl = reg_wdata[3:0];
		end
		if (reg_wr && reg_addr == REG_MEMCTL) begin
			s_d.memctl = reg_wdata[7:0];
		end
		// Register reads, data in the next cycle only
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL:   s_d.rdata = {28'h0, s_q.ctrl};
				REG_MEMCTL: s_d.rdata = {24'h0, s_q.memctl};
				REG_STATUS: s_d.rdata = {17'h0, s_q.bar_all, s_q.bar_um, s_q.busy,
					s_q.cnt_mk, s_q.cnt_um};
				default:    s_d.rdata = 32'h0000_0000;
			endcase
		end
		// Outstanding store accounting
		inc_um = st.valid && (st.io || !st.marked);
		inc_mk = st.valid && st.marked && !st.io;
		dec_um = {1'b0, st_done_valid && !st_done_marked}
			+ {1'b0, io_posted};
		dec_mk = st_done_valid && st_done_marked;
		s_d.cnt_um = s_q.cnt_um + cnt_t'(inc_um) - cnt_t'(dec_um);
		s_d.cnt_mk = s_q.cnt_mk + cnt_t'(inc_mk) - cnt_t'(dec_mk);
		// Barrier release once the covered stores have drained
		if (s_d.cnt_um == '0 && s_d.cnt_mk == '0) begin
			s_d.bar_all = 1'b0;
		end
		if (s_d.cnt_um == '0) begin
			s_d.bar_um = 1'b0;
		end
		// Barrier issue, taken even while a load is in flight
		if (iss_valid && dec.full_bar) begin
			s_d.bar_all = 1'b1;
		end
		if (iss_valid && dec.unm_bar) begin
			if (s_q.memctl[MC_WSDIS]) begin
				s_d.bar_all = 1'b1;
			end else begin
				s_d.bar_um = 1'b1;
			end
		end
		// Only later stores stall; held stores are pushed out
		s_d.stall_um = s_d.bar_all || s_d.bar_um;
		s_d.stall_mk = s_d.bar_all;
		s_d.flush    = s_d.bar_all || s_d.bar_um;
		// Remapped and legacy partial-load opcodes
		if (iss_valid && dec.nop) begin
			s_d.nop = 1'b1;
		end
		if (iss_valid && dec.partial) begin
			s_d.partial = 1'b1;
		end
		// Unaligned load sequencer
		case (s_q.fsm)
			U_IDLE: begin
				if (go && dec.unaligned_dword_load) begin
					s_d.rt = iss_insn[20:16];
					s_d.va = eff_va;
					if (!s_q.ctrl[CTL_EN64]) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_RI;
					end else if (seg_fault(eff_va, s_q.memctl)) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_ADEL;
					end else begin
						s_d.rd_req  = 1'b1;
						s_d.rd_addr = dw_align(eff_va);
						s_d.fsm     = U_WAIT0;
					end
				end
			end
			U_WAIT0: begin
				if (rd_resp.valid) begin
					s_d.d0 = rd_resp.data;
					if (rd_resp.tlb_refill) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_TLB_REFILL;
						s_d.fsm  = U_IDLE;
					end else if (rd_resp.tlb_inv) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_TLB_INV;
						s_d.fsm  = U_IDLE;
					end else if (s_q.va[2:0] == 3'h0) begin
						s_d.done = 1'b1;
						s_d.data = rd_resp.data;
						s_d.fsm  = U_IDLE;
					end else if (rd_resp.io || rd_resp.debug_segment) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_ADEL;
						s_d.fsm  = U_IDLE;
					end else if (seg_fault(next_va, s_q.memctl)) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_ADEL;
						s_d.fsm  = U_IDLE;
					end else begin
						s_d.rd_req  = 1'b1;
						s_d.rd_addr = dw_align(next_va);
						s_d.fsm     = U_WAIT1;
					end
				end
			end
			U_WAIT1: begin
				if (rd_resp.valid) begin
					s_d.fsm = U_IDLE;
					if (rd_resp.tlb_refill) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_TLB_REFILL;
					end else if (rd_resp.tlb_inv) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_TLB_INV;
					end else if (rd_resp.io || rd_resp.debug_segment) begin
						s_d.exc  = 1'b1;
						s_d.code = EXC_ADEL;
					end else begin
						s_d.done = 1'b1;
						s_d.data = merged;
					end
				end
			end
			default: begin
				s_d.fsm = U_IDLE;
			end
		endcase
		s_d.busy = s_d.fsm != U_IDLE;
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q        <= '0;
			s_q.fsm    <= U_IDLE;
			s_q.code   <= EXC_NONE;
			s_q.ctrl   <= CTRL_RST;
			s_q.memctl <= MEMCTL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata      = s_q.rdata;
	assign uld_busy       = s_q.busy;
	assign stall_unmarked = s_q.stall_um;
	assign stall_marked   = s_q.stall_mk;
	assign wb_flush       = s_q.flush;
	assign rd_req         = s_q.rd_req;
	assign rd_addr        = s_q.rd_addr;
	assign ld_done        = s_q.done;
	assign ld_rt          = s_q.rt;
	assign ld_data        = s_q.data;
	assign exc_valid      = s_q.exc;
	assign exc_code       = s_q.code;
	assign insn_nop       = s_q.nop;
	assign partial_go     = s_q.partial;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_full_stall: assert property (
		iss_valid && dec.full_bar |=> stall_unmarked && stall_marked)
		else $error("full barrier did not stall stores");
	chk_full_hold: assert property (
		s_q.bar_all && (s_q.cnt_mk != '0) && !(st_done_valid && st_done_marked)
		|=> stall_marked && stall_unmarked)
		else $error("full barrier released with stores pending");
	chk_unm_release: assert property (
		s_q.bar_um && !s_q.bar_all && !iss_valid && !st.valid
		&& (s_q.cnt_um == cnt_t'(1)) && io_posted |=> !stall_unmarked)
		else $error("posted store did not release barrier");
	chk_load_free: assert property (
		go && dec.unaligned_dword_load && s_q.ctrl[CTL_EN64] |=> rd_req || exc_valid)
		else $error("unaligned load held back");
	chk_marked_free: assert property (
		iss_valid && dec.unm_bar && !s_q.memctl[MC_WSDIS] && !s_q.bar_all
		|=> !stall_marked)
		else $error("unmarked barrier stalled marked stores");
	chk_weak_dis: assert property (
		iss_valid && dec.unm_bar && s_q.memctl[MC_WSDIS] |=> stall_marked)
		else $error("disabled weak barrier not full");
	chk_flush_tie: assert property (
		iss_valid && (dec.full_bar || dec.unm_bar) |=> wb_flush)
		else $error("barrier without write buffer flush");
	chk_ri_code: assert property (
		go && dec.unaligned_dword_load && !s_q.ctrl[CTL_EN64] |=> exc_valid && exc_code == EXC_RI)
		else $error("missing reserved instruction");
	chk_tlb_first: assert property (
		s_q.fsm == U_WAIT0 && rd_resp.valid && rd_resp.tlb_refill
		|=> exc_valid && exc_code == EXC_TLB_REFILL)
		else $error("alignment error outranked tlb refill");
	chk_second_io: assert property (
		s_q.fsm == U_WAIT1 && rd_resp.valid && rd_resp.io
		&& !rd_resp.tlb_refill && !rd_resp.tlb_inv |=> exc_valid && exc_code == EXC_ADEL)
		else $error("second doubleword in io not refused");
	chk_two_reads: assert property (
		s_q.fsm == U_WAIT0 && rd_resp.valid && s_q.va[2:0] != 3'h0
		&& !rd_resp.tlb_refill && !rd_resp.tlb_inv && !rd_resp.io
		&& !rd_resp.debug_segment && !seg_fault(next_va, s_q.memctl)
		|=> rd_req && rd_addr == dw_align($past(next_va)))
		else $error("second doubleword not fetched");

endmodule
`default_nettype wire

/* hdl/sbul_pkg.sv */
package sbul_pkg;

	// ==========================================
	// Instruction encodings
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_LEFT    = 6'h1a;
	localparam logic [5:0] OP_RIGHT   = 6'h1b;
	localparam logic [5:0] FN_SYNC    = 6'h0f;
	localparam logic [4:0] ST_FULL    = 5'h04;
	localparam logic [4:0] ST_UNM     = 5'h05;
	localparam logic [2:0] CCA_MARKED = 3'h7;

	// ==========================================
	// Register offsets, field positions, reset values
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MEMCTL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTL_UNAL  = 0;
	localparam int CTL_LONLY = 1;
	localparam int CTL_LE    = 2;
	localparam int CTL_EN64  = 3;
	localparam int MC_WSDIS  = 0;
	localparam int MC_SEGENA = 1;
	localparam int MC_LMSZ   = 2;
	localparam logic [3:0] CTRL_RST   = 4'h0;
	localparam logic [7:0] MEMCTL_RST = 8'h00;

	// ==========================================
	// Scratch segment windows
	localparam logic [63:0] LM_BASE  = 64'hffff_ffff_ffff_8000;
	localparam int          LM_TOP   = 13;
	localparam int          LM_LINE  = 7;
	localparam logic [63:0] SIO_BASE = 64'hffff_ffff_ffff_a000;
	localparam int          SIO_TOP  = 9;
	localparam logic [63:0] DW_BYTES = 64'h8;

	// ==========================================
	// Types
	localparam int CNT_W = 6;
	typedef logic [CNT_W-1:0] cnt_t;

	typedef enum logic [2:0] {
		EXC_NONE, EXC_RI, EXC_ADEL, EXC_TLB_REFILL, EXC_TLB_INV
	} exc_e;

	typedef struct packed {
		logic full_bar;
		logic unm_bar;
		logic unaligned_dword_load;
		logic nop;
		logic partial;
	} insn_dec_s;

	typedef struct packed {
		logic        valid;
		logic        marked;
		logic        io;
	} store_s;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
		logic        tlb_refill;
		logic        tlb_inv;
		logic        io;
		logic        debug_segment;
	} rd_resp_s;

endpackage

/* hdl/insn_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module insn_decode
	import sbul_pkg::*;
(
	// Instruction and steering bits
	input  wire logic [31:0] insn,
	input  wire logic        unal_en,
	input  wire logic        left_only,
	input  wire logic        little,
	// Decoded classes
	output insn_dec_s        dec
);

	// ==========================================
	// Decode
	logic sync_form;
	logic hit_left;
	logic hit_right;
	logic uld_left;

	always_comb begin
		sync_form = (insn[31:26] == OP_SPECIAL) && (insn[25:11] == 15'h0000)
			&& (insn[5:0] == FN_SYNC);
		hit_left  = (insn[31:26] == OP_LEFT);
		hit_right = (insn[31:26] == OP_RIGHT);
		uld_left  = left_only | ~little;
		dec.full_bar = sync_form && (insn[10:6] == ST_FULL);
		dec.unm_bar  = sync_form && (insn[10:6] == ST_UNM);
		dec.unaligned_dword_load      = unal_en && (uld_left ? hit_left : hit_right);
		dec.nop      = unal_en && (uld_left ? hit_right : hit_left);
		dec.partial  = ~unal_en && (hit_left | hit_right);
	end

endmodule
`default_nettype wire

/* hdl/dword_merge.sv */
`timescale 1ns/1ps
`default_nettype none
module dword_merge (
	// Two aligned doublewords and the byte offset
	input  wire logic [63:0] d0,
	input  wire logic [63:0] d1,
	input  wire logic [2:0]  lo,
	input  wire logic        big,
	// Merged result
	output logic      [63:0] q
);

	// ==========================================
	// Byte shift by eight times the offset
	logic [127:0] bw;
	logic [127:0] lw;

	always_comb begin
		bw = {d0, d1} << {lo, 3'h0};
		lw = {d1, d0} >> {lo, 3'h0};
		q  = big ? bw[127:64] : lw[63:0];
	end

endmodule
`default_nettype wire

/* test/bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_model
	import sbul_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Read request, pace and fault flags
	input  wire logic        rd_req,
	input  wire logic [63:0] rd_addr,
	input  wire logic        slow,
	input  wire logic [3:0]  err,
	// Read answer
	output rd_resp_s         rd_resp
);
	logic [63:0] a_q;
	logic [2:0]  w_q;
	logic        p_q;

	// ==========================================
	// Answer one read after one or four cycles; idle data keeps toggling, idle flags carry the inverse of err
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_resp <= '0;
			a_q <= '0;
			w_q <= 3'h0;
			p_q <= 1'b0;
		end else begin
			rd_resp.valid <= 1'b0;
			rd_resp.data <= ~rd_resp.data;
			{rd_resp.tlb_refill, rd_resp.tlb_inv, rd_resp.io, rd_resp.debug_segment} <= ~err;
			if (rd_req) begin
				a_q <= rd_addr;
				w_q <= slow ? 3'h3 : 3'h0;
				p_q <= 1'b1;
			end else if (p_q && w_q == 3'h0) begin
				rd_resp.valid <= 1'b1;
				rd_resp.data <= {~a_q[31:0], a_q[31:0]};
				{rd_resp.tlb_refill, rd_resp.tlb_inv, rd_resp.io, rd_resp.debug_segment} <= err;
				p_q <= 1'b0;
			end else if (p_q) begin
				w_q <= w_q - 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* test/store_barrier_unaligned_load_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module store_barrier_unaligned_load_tb_top
	import sbul_pkg::*;
;
	typedef struct packed {
		logic [2:0]  k;
		logic [4:0]  r;
		logic [63:0] v;
	} note_s;
	localparam logic [31:0] FULL = {OP_SPECIAL, 15'h0, ST_FULL, FN_SYNC};
	localparam logic [31:0] UNM  = {OP_SPECIAL, 15'h0, ST_UNM, FN_SYNC};
	logic        clk = 1'b0;
	logic        resetn, reg_wr, reg_rd, iss_valid, uld_busy, slow;
	logic        st_done_valid, st_done_marked, io_posted, stall_unmarked;
	logic        stall_marked, wb_flush, rd_req, ld_done, exc_valid;
	logic        insn_nop, partial_go, rd_pend;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, iss_insn;
	logic [63:0] iss_base, rd_addr, ld_data;
	logic [4:0]  ld_rt;
	logic [3:0]  err;
	logic [2:0]  kd;
	store_s      st;
	rd_resp_s    rd_resp;
	exc_e        exc_code;
	note_s       q[$];
	note_s       nt;
	int          n_fail, n_tests, seed;

	// ==========================================
	// Clock, design and far side
	always #4 clk = ~clk;

	sbul_core u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.iss_valid, .iss_insn, .iss_base, .uld_busy, .st, .st_done_valid, .st_done_marked,
		.io_posted, .stall_unmarked, .stall_marked, .wb_flush, .rd_req, .rd_addr, .rd_resp,
		.ld_done, .ld_rt, .ld_data, .exc_valid, .exc_code, .insn_nop, .partial_go);

	bus_model u_mem (.clk, .resetn, .rd_req, .rd_addr, .slow, .err, .rd_resp);

	// ==========================================
	// Compare, report and end
	task automatic chk(string n, logic [63:0] e, logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("Counts: %0d checks, %0d errors", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Wait, bounded, until every note is matched
	task automatic drain();
		for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge clk);
		if (q.size() > 0) begin
			chk("pending", 64'h0, 64'(q.size()));
			wrap_up();
		end
	endtask

	// ==========================================
	// Drivers
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [63:0] e);
		q.push_back({3'h4, 5'h0, e});
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		drain();
	endtask

	task automatic iss(logic [31:0] w, logic [63:0] b);
		@(posedge clk);
		iss_valid <= 1'b1;
		iss_insn <= w;
		iss_base <= b;
		@(posedge clk);
		iss_valid <= 1'b0;
	endtask

	// Issue a load-class opcode; kinds 0 data, 1 exception, 2 nop, 3 partial
	task automatic ld(logic [5:0] op, logic [63:0] b, logic [15:0] off, logic [2:0] k,
		logic [63:0] v);
		q.push_back({k, 5'd7, v});
		slow <= ^$random(seed);
		iss({op, 5'd1, 5'd7, off}, b);
		if (k == 3'h0) begin
			@(posedge clk);
			chk("uld_busy", 64'h1, 64'(uld_busy));
		end
		drain();
	endtask

	// One store start and completion pulse: d is {done, done marked, posted}
	task automatic stp(store_s s, logic [2:0] d);
		@(posedge clk);
		st <= s;
		{st_done_valid, st_done_marked, io_posted} <= d;
		@(posedge clk);
		st <= '0;
		{st_done_valid, st_done_marked, io_posted} <= 3'h0;
	endtask

	task automatic ck(logic u, logic m);
		@(posedge clk);
		chk("stall_unmarked", 64'(u), 64'(stall_unmarked));
		chk("stall_marked", 64'(m), 64'(stall_marked));
		chk("wb_flush", 64'(u), 64'(wb_flush));
	endtask

	// ==========================================
	// Expected load data
	function automatic logic [63:0] pat(logic [63:0] a);
		return {~a[31:0], a[31:0]};
	endfunction

	function automatic logic [63:0] mrg(logic [63:0] va, logic be);
		logic [127:0] t;
		logic [63:0]  a;
		a = {va[63:3], 3'h0};
		if (be) t = {pat(a), pat(a + DW_BYTES)} << (8 * va[2:0]);
		else t = {64'h0, 64'({pat(a + DW_BYTES), pat(a)} >> (8 * va[2:0]))};
		return be ? t[127:64] : t[63:0];
	endfunction

	// ==========================================
	// Match each result against the oldest note
	always @(posedge clk) begin
		rd_pend <= reg_rd;
		kd = ld_done ? 3'h0 : exc_valid ? 3'h1 : insn_nop ? 3'h2 : partial_go ? 3'h3 : 3'h4;
		if (ld_done | exc_valid | insn_nop | partial_go | rd_pend) begin
			if (q.size() == 0) begin
				chk("unexpected result", 64'h0, 64'h1);
			end else begin
				nt = q.pop_front();
				chk("kind", 64'(nt.k), 64'(kd));
				if (nt.k == 3'h0) chk("ld_data", nt.v, ld_data);
				if (nt.k == 3'h0) chk("ld_rt", 64'(nt.r), 64'(ld_rt));
				if (nt.k == 3'h1) chk("exc_code", nt.v, 64'(exc_code));
				if (nt.k == 3'h4) chk("reg_rdata", nt.v, 64'(reg_rdata));
			end
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [63:0] b;
		logic [15:0] off;
		logic [5:0]  op;
		{resetn, reg_wr, reg_rd, iss_valid, slow} = 5'h0;
		{st_done_valid, st_done_marked, io_posted, st, err} = 10'h0;
		{reg_addr, reg_wdata, iss_insn, iss_base} = '0;
		{n_fail, n_tests, seed} = {32'd0, 32'd0, 32'd86};
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(REG_CTRL, 64'h0);
		rd(REG_MEMCTL, 64'h0);
		rd(8'h40, 64'h0);
		wr(REG_CTRL, 32'h1);
		ld(OP_LEFT, 64'h100, 16'h0, 3'h1, 64'(EXC_RI));
		wr(REG_CTRL, 32'h8);
		ld(OP_LEFT, 64'h100, 16'h0, 3'h3, 64'h0);
		wr(REG_CTRL, 32'h9);
		rd(REG_CTRL, 64'h9);
		// Big-endian, little-endian, then left-only, every byte offset
		for (int j = 0; j < 3; j++) begin
			wr(REG_CTRL, j == 0 ? 32'h9 : (j == 1 ? 32'hd : 32'hf));
			op = (j == 1) ? OP_RIGHT : OP_LEFT;
			for (int i = 0; i < 8; i++) begin
				b = {32'h0, 2'b01, 26'($random(seed)), 4'h0};
				off = {13'($random(seed)), i[2:0]};
				ld(op, b, off, 3'h0, mrg(b + {{48{off[15]}}, off}, j == 0));
				ld(op ^ 6'h1, b, off, 3'h2, 64'h0);
			end
		end
		// Faults reported with the read answers
		wr(REG_CTRL, 32'h9);
		err <= 4'h2;
		ld(OP_LEFT, 64'h4000_0000, 16'h3, 3'h1, 64'(EXC_ADEL));
		ld(OP_LEFT, 64'h4000_0000, 16'h8, 3'h0, pat(64'h4000_0008));
		err <= 4'ha;
		ld(OP_LEFT, 64'h4000_0000, 16'h5, 3'h1, 64'(EXC_TLB_REFILL));
		err <= 4'h6;
		ld(OP_LEFT, 64'h4000_0000, 16'h6, 3'h1, 64'(EXC_TLB_INV));
		err <= 4'h1;
		ld(OP_LEFT, 64'h4000_0000, 16'h1, 3'h1, 64'(EXC_ADEL));
		err <= 4'h0;
		// Clean first doubleword, second one answered from I/O space
		q.push_back({3'h1, 5'd7, 64'(EXC_ADEL)});
		slow <= 1'b0;
		iss({OP_LEFT, 5'd1, 5'd7, 16'h4}, 64'h4000_0000);
		for (int i = 0; i < 20 && !rd_resp.valid; i++) @(posedge clk);
		err <= 4'h2;
		drain();
		err <= 4'h0;
		wr(REG_MEMCTL, 32'h2);
		ld(OP_LEFT, SIO_BASE, 16'h0, 3'h1, 64'(EXC_ADEL));
		ld(OP_LEFT, LM_BASE + 64'h80, 16'h0, 3'h1, 64'(EXC_ADEL));
		ld(OP_LEFT, LM_BASE, 16'h3, 3'h0, mrg(LM_BASE + 64'h3, 1'b1));
		// Store barriers
		wr(REG_MEMCTL, 32'h0);
		stp(3'b100, 3'h0);
		iss(FULL, 64'h0);
		ck(1'b1, 1'b1);
		ld(OP_LEFT, 64'h4000_0010, 16'h0, 3'h0, pat(64'h4000_0010));
		ck(1'b1, 1'b1);
		stp(3'b000, 3'b100);
		ck(1'b0, 1'b0);
		stp(3'b110, 3'h0);
		stp(3'b101, 3'h0);
		rd(REG_STATUS, 64'h41);
		iss(UNM, 64'h0);
		ck(1'b1, 1'b0);
		stp(3'b000, 3'b001);
		ck(1'b0, 1'b0);
		stp(3'b000, 3'b110);
		wr(REG_MEMCTL, 32'h1);
		stp(3'b110, 3'h0);
		iss(UNM, 64'h0);
		ck(1'b1, 1'b1);
		stp(3'b000, 3'b110);
		ck(1'b0, 1'b0);
		drain();
		wrap_up();
	end
endmodule
`default_nettype wire
